// ### core/txoh_pkg.sv
// constants of the per-port transmit overhead and stuffing block
package txoh_pkg;
   localparam int          NUM_PORTS        = 4;
   localparam int          ADDR_W           = 11;
   localparam int          OFF_W            = 9;
   // per-port copies sit 200h apart, port number in the top address bits
   localparam int          PORT_LSB         = 9;
   // register offsets inside one port
   localparam logic [8:0]  OFF_JAM_SEL1     = 9'h104;
   localparam logic [8:0]  OFF_JAM_SEL4     = 9'h107;
   localparam logic [8:0]  OFF_DDS_SEL1     = 9'h108;
   localparam logic [8:0]  OFF_DDS_SEL3     = 9'h10A;
   localparam logic [8:0]  OFF_FDL          = 9'h162;
   localparam logic [8:0]  OFF_BOC          = 9'h163;
   localparam logic [8:0]  OFF_SHARED1      = 9'h164;
   localparam logic [8:0]  OFF_SHARED2      = 9'h165;
   localparam logic [8:0]  OFF_SHARED3      = 9'h166;
   localparam logic [8:0]  OFF_SI_ODD       = 9'h167;
   localparam logic [8:0]  OFF_RA_BITS      = 9'h168;
   localparam logic [8:0]  OFF_SA4_BITS     = 9'h169;
   localparam logic [8:0]  OFF_SA5_BITS     = 9'h16A;
   localparam logic [8:0]  OFF_CTRL         = 9'h170;
   localparam logic [8:0]  OFF_JAM_VALUE    = 9'h171;
   localparam logic [8:0]  OFF_DDS_VALUE    = 9'h172;
   // control register fields
   localparam int          CTRL_E1_MODE     = 0;
   localparam int          CTRL_D4_MODE     = 1;
   localparam int          CTRL_JAM_EN      = 2;
   localparam int          CTRL_DDS_EN      = 3;
   localparam int          CTRL_PASS_TS0    = 4;
   localparam int          CTRL_SLC96       = 5;
   // reset values
   localparam logic [7:0]  RST_ZERO         = 8'h00;
   localparam logic [7:0]  RST_ALIGN_WORD   = 8'h1B;
   localparam logic [7:0]  RST_NONALIGN     = 8'h40;
   localparam logic [7:0]  RST_JAM_VALUE    = 8'h01;
   localparam logic [7:0]  RST_DDS_VALUE    = 8'h7F;
   // field masks and fixed bits
   localparam logic [7:0]  BOC_MASK         = 8'h3F;
   localparam logic [7:0]  NONALIGN_FIXED   = 8'h40;
   localparam logic [4:0]  T1_CHANNELS      = 5'd24;
   localparam logic [2:0]  FDL_LAST_FULL    = 3'd7;
   localparam logic [2:0]  FDL_LAST_D4      = 3'd5;
   localparam logic [4:0]  SLC_BITS         = 5'd24;
endpackage

// ### core/txoh_regs.sv
// transmit overhead insertion, channel stuffing and register copies
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
// What this block does
// - jam-selected all-zero channel gets stuff value
// - jam stuffing only with the port's own jam enable
// - three DDS selects, gated by DDS enable
// - DDS pattern replaces selected all-zero channel
// - data link byte sent LSB first
// - D4 framing uses low six bits
// - code register holds six bits, top zero
// - SLC-96 registers feed C, M, A, S bits
// - E1 mode maps E1 words onto SLC addresses
// - align word: Si bit, pattern 0011011 default
// - non-align word: Si, 1, alarm, Sa4-Sa8
// - in E1 mode without pass-through, slot zero built internally
// - even-frame Si bits, frame 0 in bit 0
// - odd-frame Si bits, frame 1 in bit 0
// - odd-frame remote alarm bits, reset zero
// - four register copies spaced 200h apart
module txoh_regs
   import txoh_pkg::*;
#(
   parameter int NPORT = NUM_PORTS
)(
   input  wire logic              clk_sys_in,
   input  wire logic              nrst_in,
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [7:0]        reg_rdata_out,
   input  wire logic              ch_valid_in,
   input  wire logic [1:0]        ch_port_in,
   input  wire logic [4:0]        ch_num_in,
   input  wire logic [3:0]        ch_frame_in,
   input  wire logic [7:0]        serial_transmit_input_in,
   output logic                   ch_valid_out,
   output logic      [7:0]        ch_byte_out,
   input  wire logic              oh_bit_req_in,
   input  wire logic [1:0]        oh_port_in,
   input  wire logic [4:0]        oh_index_in,
   output logic                   oh_bit_valid_out,
   output logic                   oh_bit_out
);

   logic [7:0] jam_bit8_channel_select [NPORT][4];
   logic [7:0] dds_zero_select         [NPORT][3];
   logic [7:0] tx_facility_data_link   [NPORT];
   logic [7:0] tx_bit_oriented_code    [NPORT];
   logic [7:0] tx_slc96_link           [NPORT][3];
   logic [7:0] tx_align_frame_word     [NPORT];
   logic [7:0] tx_nonalign_frame_word  [NPORT];
   logic [7:0] tx_intl_bits_even_frames[NPORT];
   logic [7:0] tx_intl_bits_odd_frames [NPORT];
   logic [7:0] tx_remote_alarm_bits    [NPORT];
   logic [7:0] tx_national_bit4_frames [NPORT];
   logic [7:0] tx_national_bit5_frames [NPORT];
   logic [7:0] tx_control              [NPORT];
   logic [7:0] jam_bit8_stuff_value    [NPORT];
   logic [7:0] dds_stuff_value         [NPORT];
   logic [2:0] fdl_bit_cnt             [NPORT];

   // address split into port copy and offset
   logic [1:0]       acc_port;
   logic [OFF_W-1:0] acc_off;
   logic             acc_e1;
   logic [7:0]       rd_value;
   logic [7:0]       next_rdata;

   assign acc_port = reg_addr_in[ADDR_W-1:PORT_LSB];
   assign acc_off  = reg_addr_in[OFF_W-1:0];
   assign acc_e1   = tx_control[acc_port][CTRL_E1_MODE];

   function automatic logic in_range(input logic [8:0] off,
                                     input logic [8:0] lo,
                                     input logic [8:0] hi);
      return (off >= lo) && (off <= hi);
   endfunction

   function automatic logic [7:0] read_mux(input logic [1:0] p,
                                           input logic [8:0] off,
                                           input logic       e1);
      logic [7:0] v;
      v = RST_ZERO;
      if (in_range(off, OFF_JAM_SEL1, OFF_JAM_SEL4))
         v = jam_bit8_channel_select[p][2'(off - OFF_JAM_SEL1)];
      else if (in_range(off, OFF_DDS_SEL1, OFF_DDS_SEL3))
         v = dds_zero_select[p][2'(off - OFF_DDS_SEL1)];
      else begin
         unique case (off)
            OFF_FDL:       v = tx_facility_data_link[p];
            OFF_BOC:       v = tx_bit_oriented_code[p];
            // shared addresses follow the port mode
            OFF_SHARED1:   v = e1 ? tx_align_frame_word[p]
                                  : tx_slc96_link[p][0];
            OFF_SHARED2:   v = e1 ? tx_nonalign_frame_word[p]
                                  : tx_slc96_link[p][1];
            OFF_SHARED3:   v = e1 ? tx_intl_bits_even_frames[p]
                                  : tx_slc96_link[p][2];
            OFF_SI_ODD:    v = tx_intl_bits_odd_frames[p];
            OFF_RA_BITS:   v = tx_remote_alarm_bits[p];
            OFF_SA4_BITS:  v = tx_national_bit4_frames[p];
            OFF_SA5_BITS:  v = tx_national_bit5_frames[p];
            OFF_CTRL:      v = tx_control[p];
            OFF_JAM_VALUE: v = jam_bit8_stuff_value[p];
            OFF_DDS_VALUE: v = dds_stuff_value[p];
            default:       v = RST_ZERO;
         endcase
      end
      return v;
   endfunction

   // process form, so stored values retrigger the lookup
   always_comb begin
      rd_value = read_mux(acc_port, acc_off, acc_e1);
   end
   assign next_rdata = reg_rd_in ? rd_value : RST_ZERO;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= RST_ZERO;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // write strobes decoded once per offset
   logic       wr_jam_sel;
   logic       wr_dds_sel;
   logic       wr_fdl;
   logic       wr_boc;
   logic       wr_shared1;
   logic       wr_shared2;
   logic       wr_shared3;
   logic       wr_si_odd;
   logic       wr_ra;
   logic       wr_sa4;
   logic       wr_sa5;
   logic       wr_ctrl;
   logic       wr_jam_value;
   logic       wr_dds_value;
   logic [1:0] jam_idx;
   logic [1:0] dds_idx;

   assign wr_jam_sel   = reg_wr_in &&
                         in_range(acc_off, OFF_JAM_SEL1, OFF_JAM_SEL4);
   assign wr_dds_sel   = reg_wr_in &&
                         in_range(acc_off, OFF_DDS_SEL1, OFF_DDS_SEL3);
   assign wr_fdl       = reg_wr_in && (acc_off == OFF_FDL);
   assign wr_boc       = reg_wr_in && (acc_off == OFF_BOC);
   assign wr_shared1   = reg_wr_in && (acc_off == OFF_SHARED1);
   assign wr_shared2   = reg_wr_in && (acc_off == OFF_SHARED2);
   assign wr_shared3   = reg_wr_in && (acc_off == OFF_SHARED3);
   assign wr_si_odd    = reg_wr_in && (acc_off == OFF_SI_ODD);
   assign wr_ra        = reg_wr_in && (acc_off == OFF_RA_BITS);
   assign wr_sa4       = reg_wr_in && (acc_off == OFF_SA4_BITS);
   assign wr_sa5       = reg_wr_in && (acc_off == OFF_SA5_BITS);
   assign wr_ctrl      = reg_wr_in && (acc_off == OFF_CTRL);
   assign wr_jam_value = reg_wr_in && (acc_off == OFF_JAM_VALUE);
   assign wr_dds_value = reg_wr_in && (acc_off == OFF_DDS_VALUE);
   assign jam_idx      = 2'(acc_off - OFF_JAM_SEL1);
   assign dds_idx      = 2'(acc_off - OFF_DDS_SEL1);

   // channel select registers
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NPORT; p++) begin
            for (int i = 0; i < 4; i++) begin
               jam_bit8_channel_select[p][i] <= RST_ZERO;
            end
            for (int i = 0; i < 3; i++) begin
               dds_zero_select[p][i] <= RST_ZERO;
            end
         end
      end else begin
         if (wr_jam_sel) begin
            jam_bit8_channel_select[acc_port][jam_idx] <= reg_wdata_in;
         end
         if (wr_dds_sel) begin
            dds_zero_select[acc_port][dds_idx] <= reg_wdata_in;
         end
      end
   end

   // T1 data link, code and SLC-96 words
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NPORT; p++) begin
            tx_facility_data_link[p] <= RST_ZERO;
            tx_bit_oriented_code[p]  <= RST_ZERO;
            for (int i = 0; i < 3; i++) begin
               tx_slc96_link[p][i] <= RST_ZERO;
            end
         end
      end else begin
         if (wr_fdl) begin
            tx_facility_data_link[acc_port] <= reg_wdata_in;
         end
         if (wr_boc) begin
            tx_bit_oriented_code[acc_port] <= reg_wdata_in & BOC_MASK;
         end
         if (wr_shared1 && !acc_e1) begin
            tx_slc96_link[acc_port][0] <= reg_wdata_in;
         end
         if (wr_shared2 && !acc_e1) begin
            tx_slc96_link[acc_port][1] <= reg_wdata_in;
         end
         if (wr_shared3 && !acc_e1) begin
            tx_slc96_link[acc_port][2] <= reg_wdata_in;
         end
      end
   end

   // E1 frame words and per-frame Si bits
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NPORT; p++) begin
            tx_align_frame_word[p]      <= RST_ALIGN_WORD;
            tx_nonalign_frame_word[p]   <= RST_NONALIGN;
            tx_intl_bits_even_frames[p] <= RST_ZERO;
            tx_intl_bits_odd_frames[p]  <= RST_ZERO;
         end
      end else begin
         if (wr_shared1 && acc_e1) begin
            tx_align_frame_word[acc_port] <= reg_wdata_in;
         end
         if (wr_shared2 && acc_e1) begin
            tx_nonalign_frame_word[acc_port]
               <= reg_wdata_in | NONALIGN_FIXED;
         end
         if (wr_shared3 && acc_e1) begin
            tx_intl_bits_even_frames[acc_port] <= reg_wdata_in;
         end
         if (wr_si_odd) begin
            tx_intl_bits_odd_frames[acc_port] <= reg_wdata_in;
         end
      end
   end

   // E1 per-frame alarm and national bits
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NPORT; p++) begin
            tx_remote_alarm_bits[p]    <= RST_ZERO;
            tx_national_bit4_frames[p] <= RST_ZERO;
            tx_national_bit5_frames[p] <= RST_ZERO;
         end
      end else begin
         if (wr_ra) begin
            tx_remote_alarm_bits[acc_port] <= reg_wdata_in;
         end
         if (wr_sa4) begin
            tx_national_bit4_frames[acc_port] <= reg_wdata_in;
         end
         if (wr_sa5) begin
            tx_national_bit5_frames[acc_port] <= reg_wdata_in;
         end
      end
   end

   // port control and stuffing values
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < NPORT; p++) begin
            tx_control[p]           <= RST_ZERO;
            jam_bit8_stuff_value[p] <= RST_JAM_VALUE;
            dds_stuff_value[p]      <= RST_DDS_VALUE;
         end
      end else begin
         if (wr_ctrl) begin
            tx_control[acc_port] <= reg_wdata_in;
         end
         if (wr_jam_value) begin
            jam_bit8_stuff_value[acc_port] <= reg_wdata_in;
         end
         if (wr_dds_value) begin
            dds_stuff_value[acc_port] <= reg_wdata_in;
         end
      end
   end

   // channel stream: stuffing and slot zero
   logic [7:0] cur_ctrl;
   logic       cur_e1;
   logic       ch_all_zero;
   logic       jam_sel_bit;
   logic       dds_sel_bit;
   logic       jam_hit;
   logic       dds_hit;
   logic [2:0] mf_pair;
   logic       si_bit;
   logic [7:0] ts0_align;
   logic [7:0] ts0_nonalign;
   logic       ts0_hit;
   logic [7:0] next_byte;

   assign cur_ctrl    = tx_control[ch_port_in];
   assign cur_e1      = cur_ctrl[CTRL_E1_MODE];
   assign ch_all_zero = (serial_transmit_input_in == RST_ZERO);
   assign jam_sel_bit =
      jam_bit8_channel_select[ch_port_in][ch_num_in[4:3]][ch_num_in[2:0]];
   assign dds_sel_bit = (ch_num_in < T1_CHANNELS) &&
      dds_zero_select[ch_port_in][ch_num_in[4:3]][ch_num_in[2:0]];
   assign jam_hit = cur_ctrl[CTRL_JAM_EN] && jam_sel_bit &&
                    (cur_e1 || ch_num_in < T1_CHANNELS) &&
                    ch_all_zero;
   assign dds_hit = !cur_e1 && cur_ctrl[CTRL_DDS_EN] &&
                    dds_sel_bit && ch_all_zero;

   // frame pair index: frames 2k and 2k+1 share bit k
   assign mf_pair = ch_frame_in[3:1];
   assign si_bit  = ch_frame_in[0]
      ? tx_intl_bits_odd_frames[ch_port_in][mf_pair]
      : tx_intl_bits_even_frames[ch_port_in][mf_pair];
   assign ts0_align = {si_bit,
                       tx_align_frame_word[ch_port_in][6:0]};
   assign ts0_nonalign = {si_bit, 1'b1,
      tx_remote_alarm_bits[ch_port_in][mf_pair],
      tx_national_bit4_frames[ch_port_in][mf_pair],
      tx_national_bit5_frames[ch_port_in][mf_pair],
      tx_nonalign_frame_word[ch_port_in][2:0]};
   assign ts0_hit = cur_e1 && (ch_num_in == 5'd0) &&
                    !cur_ctrl[CTRL_PASS_TS0];

   assign next_byte = ts0_hit ? (ch_frame_in[0] ? ts0_nonalign
                                                : ts0_align)
                    : jam_hit ? jam_bit8_stuff_value[ch_port_in]
                    : dds_hit ? dds_stuff_value[ch_port_in]
                    : serial_transmit_input_in;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ch_valid_out <= 1'b0;
         ch_byte_out  <= RST_ZERO;
      end else begin
         ch_valid_out <= ch_valid_in;
         if (ch_valid_in) begin
            ch_byte_out <= next_byte;
         end
      end
   end

   // overhead bit stream: data link or SLC-96 word
   logic [7:0]  oh_ctrl;
   logic        oh_slc;
   logic [2:0]  oh_cnt;
   logic [2:0]  fdl_last;
   logic        fdl_bit;
   logic [23:0] slc_word;
   logic        slc_bit;
   logic        next_oh_bit;

   assign oh_ctrl  = tx_control[oh_port_in];
   assign oh_slc   = oh_ctrl[CTRL_SLC96] && !oh_ctrl[CTRL_E1_MODE];
   assign oh_cnt   = fdl_bit_cnt[oh_port_in];
   assign fdl_last = oh_ctrl[CTRL_D4_MODE] ? FDL_LAST_D4
                                           : FDL_LAST_FULL;
   assign fdl_bit  = tx_facility_data_link[oh_port_in][oh_cnt];
   // fixed S=0 and S=1 positions override the stored bits
   assign slc_word = {1'b1, tx_slc96_link[oh_port_in][2][6:0],
                      tx_slc96_link[oh_port_in][1][7:6], 3'b010,
                      tx_slc96_link[oh_port_in][1][2:0],
                      tx_slc96_link[oh_port_in][0]};
   assign slc_bit  = (oh_index_in < SLC_BITS) ? slc_word[oh_index_in]
                                              : 1'b0;
   assign next_oh_bit = oh_slc ? slc_bit : fdl_bit;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         oh_bit_valid_out <= 1'b0;
         oh_bit_out       <= 1'b0;
         for (int p = 0; p < NPORT; p++) begin
            fdl_bit_cnt[p] <= 3'd0;
         end
      end else begin
         oh_bit_valid_out <= oh_bit_req_in;
         if (oh_bit_req_in) begin
            oh_bit_out <= next_oh_bit;
            if (!oh_slc) begin
               // LSB first, wrap after the last used bit
               fdl_bit_cnt[oh_port_in] <= (oh_cnt >= fdl_last)
                                          ? 3'd0 : oh_cnt + 3'd1;
            end
         end
      end
   end

endmodule

// ### test/txoh_regs_asserts.sv
// concurrent checks on the transmit overhead block ports
`timescale 1ns/10ps
module txoh_regs_asserts
   import txoh_pkg::*;
(
   input wire logic              clk_sys_in,
   input wire logic              nrst_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic              reg_rd_in,
   input wire logic [7:0]        reg_rdata_out,
   input wire logic              ch_valid_in,
   input wire logic [4:0]        ch_num_in,
   input wire logic [7:0]        serial_transmit_input_in,
   input wire logic              ch_valid_out,
   input wire logic [7:0]        ch_byte_out,
   input wire logic              oh_bit_req_in,
   input wire logic              oh_bit_valid_out,
   input wire logic              oh_bit_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // nonzero byte outside slot zero is never stuffed
   sequence s_live_byte;
      ch_valid_in && ch_num_in != 5'h00 && serial_transmit_input_in != 8'h00;
   endsequence
   sequence s_code_read;
      reg_rd_in && reg_addr_in[8:0] == OFF_BOC;
   endsequence
   sequence s_idle3;
      ch_valid_in ##1 !ch_valid_in [*3];
   endsequence
   property p_valid_follow; ch_valid_in |=> ch_valid_out; endproperty
   property p_valid_only;
      !ch_valid_in |=> !ch_valid_out && $stable(ch_byte_out);
   endproperty
   property p_pass_live;
      s_live_byte |=> ch_byte_out == $past(serial_transmit_input_in);
   endproperty
   property p_hold_byte; s_idle3 |-> ch_byte_out == $past(ch_byte_out, 2);
   endproperty
   property p_oh_follow; oh_bit_req_in |=> oh_bit_valid_out; endproperty
   property p_oh_quiet;
      !oh_bit_req_in |=> !oh_bit_valid_out && $stable(oh_bit_out);
   endproperty
   property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
   property p_code_top; s_code_read |=> reg_rdata_out[7:6] == 2'b00;
   endproperty
   a_valid_follow: assert property (p_valid_follow)
      else $error("output valid missing");
   a_valid_only: assert property (p_valid_only)
      else $error("output moved without valid");
   a_pass_live: assert property (p_pass_live)
      else $error("nonzero byte altered");
   a_hold_byte: assert property (p_hold_byte)
      else $error("byte not held");
   a_oh_follow: assert property (p_oh_follow)
      else $error("overhead valid missing");
   a_oh_quiet: assert property (p_oh_quiet)
      else $error("overhead bit moved unasked");
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   a_code_top: assert property (p_code_top)
      else $error("code register top bits set");
endmodule

bind txoh_regs txoh_regs_asserts u_chk (.clk_sys_in, .nrst_in, .reg_addr_in,
   .reg_rd_in, .reg_rdata_out, .ch_valid_in, .ch_num_in,
   .serial_transmit_input_in, .ch_valid_out, .ch_byte_out, .oh_bit_req_in,
   .oh_bit_valid_out, .oh_bit_out);

// ### test/txoh_line_sink.sv
// line-side sink that gathers overhead bits as they are sent
`timescale 1ns/10ps
module txoh_line_sink (
   input  wire logic       clk_sys_in,
   input  wire logic       nrst_in,
   input  wire logic       oh_valid_in,
   input  wire logic       oh_bit_in,
   output logic      [7:0] oh_word_out
);
   // first bit heard lands in bit 0 after eight bits
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         oh_word_out <= 8'h00;
      end else if (oh_valid_in) begin
         oh_word_out <= {oh_bit_in, oh_word_out[7:1]};
      end
   end
endmodule

// ### test/tb_tx_overhead_insertion_regs.sv
// self-checking bench for the transmit overhead block
`timescale 1ns/10ps
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
$display("unexpected at %0t got %h exp %h", $time, a, b); end end
module tb_tx_overhead_insertion_regs
   import txoh_pkg::*;
();
   localparam logic [7:0] LINK_BYTE = 8'h25;
   logic              clk_sys_in, nrst_in, reg_wr_in, reg_rd_in;
   logic              ch_valid_in, oh_bit_req_in;
   logic              ch_valid_out, oh_bit_valid_out, oh_bit_out;
   logic [ADDR_W-1:0] reg_addr_in;
   logic [7:0]        reg_wdata_in, serial_transmit_input_in;
   logic [7:0]        reg_rdata_out, ch_byte_out, heard;
   logic [1:0]        ch_port_in, oh_port_in;
   logic [4:0]        ch_num_in, oh_index_in;
   logic [3:0]        ch_frame_in;
   int                fails, samples_checked, cycles;

   txoh_regs #(.NPORT(NUM_PORTS)) dut (.clk_sys_in, .nrst_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ch_valid_in,
      .ch_port_in, .ch_num_in, .ch_frame_in, .serial_transmit_input_in,
      .ch_valid_out, .ch_byte_out, .oh_bit_req_in, .oh_port_in,
      .oh_index_in, .oh_bit_valid_out, .oh_bit_out);
   txoh_line_sink sink (.clk_sys_in, .nrst_in, .oh_valid_in(oh_bit_valid_out),
      .oh_bit_in(oh_bit_out), .oh_word_out(heard));

   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 4000) begin
         fails++;
         print_verdict();
      end
   end

   task wr(input logic [1:0] p, input logic [8:0] o, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_in  <= {p, o};
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b0;
   endtask
   task rd(input logic [1:0] p, input logic [8:0] o, input logic [7:0] e);
      @(posedge clk_sys_in);
      reg_addr_in <= {p, o};
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_sys_in);
      `CHK(reg_rdata_out, e)
   endtask
   task chan(input logic [1:0] p, input logic [4:0] n, input logic [3:0] f,
             input logic [7:0] b, input logic [7:0] e);
      @(posedge clk_sys_in);
      ch_valid_in              <= 1'b1;
      ch_port_in               <= p;
      ch_num_in                <= n;
      ch_frame_in              <= f;
      serial_transmit_input_in <= b;
      @(posedge clk_sys_in);
      ch_valid_in <= 1'b0;
      @(negedge clk_sys_in);
      `CHK({ch_valid_out, ch_byte_out}, {1'b1, e})
   endtask
   task oh(input logic [4:0] i, input logic e);
      @(posedge clk_sys_in);
      oh_bit_req_in <= 1'b1;
      oh_index_in   <= i;
      @(posedge clk_sys_in);
      oh_bit_req_in <= 1'b0;
      @(negedge clk_sys_in);
      `CHK({oh_bit_valid_out, oh_bit_out}, {1'b1, e})
   endtask

   task test_regs;
      rd(0, OFF_FDL, 8'h00);
      rd(0, OFF_SHARED1, 8'h00);
      wr(0, OFF_CTRL, 8'h01);
      rd(0, OFF_SHARED1, 8'h1B);
      rd(0, OFF_SHARED2, 8'h40);
      for (int o = 'h166; o <= 'h16A; o++) rd(0, o[8:0], 8'h00);
      rd(0, 9'h1FF, 8'h00);
      wr(0, OFF_BOC, 8'hFF);
      rd(0, OFF_BOC, 8'h3F);
      wr(3, OFF_BOC, 8'h2A);
      rd(3, OFF_BOC, 8'h2A);
      rd(0, OFF_BOC, 8'h3F);
      $display("register test done");
   endtask
   task test_stuff;
      wr(0, OFF_CTRL, 8'h04);
      wr(0, OFF_JAM_SEL1, 8'h04);
      chan(0, 5'd2, 4'd0, 8'h00, 8'h01);
      chan(0, 5'd1, 4'd0, 8'h00, 8'h00);
      chan(0, 5'd2, 4'd0, 8'h5A, 8'h5A);
      chan(1, 5'd2, 4'd0, 8'h00, 8'h00);
      wr(0, OFF_CTRL, 8'h00);
      chan(0, 5'd2, 4'd0, 8'h00, 8'h00);
      wr(0, OFF_CTRL, 8'h08);
      wr(0, OFF_DDS_SEL3, 8'h80);
      wr(0, OFF_DDS_SEL1, 8'h01);
      chan(0, 5'd23, 4'd0, 8'h00, 8'h7F);
      chan(0, 5'd0, 4'd0, 8'h00, 8'h7F);
      chan(0, 5'd22, 4'd0, 8'h00, 8'h00);
      wr(0, OFF_CTRL, 8'h00);
      chan(0, 5'd23, 4'd0, 8'h00, 8'h00);
      $display("stuffing test done");
   endtask
   task test_link;
      wr(0, OFF_FDL, LINK_BYTE);
      for (int i = 0; i < 8; i++) oh(5'd0, LINK_BYTE[i]);
      @(negedge clk_sys_in);
      `CHK(heard, LINK_BYTE)
      wr(0, OFF_CTRL, 8'h02);
      for (int i = 0; i < 6; i++) oh(5'd0, LINK_BYTE[i]);
      oh(5'd0, LINK_BYTE[0]);
      wr(0, OFF_CTRL, 8'h20);
      wr(0, OFF_SHARED1, 8'hFF);
      wr(0, OFF_SHARED2, 8'h00);
      wr(0, OFF_SHARED3, 8'h00);
      oh(5'd0, 1'b1);
      oh(5'd12, 1'b1);
      oh(5'd23, 1'b1);
      oh(5'd24, 1'b0);
      wr(0, OFF_SHARED2, 8'hFF);
      oh(5'd13, 1'b0);
      oh(5'd11, 1'b0);
      oh(5'd10, 1'b1);
      oh(5'd22, 1'b0);
      $display("link test done");
   endtask
   task test_e1;
      wr(0, OFF_CTRL, 8'h01);
      rd(0, OFF_SHARED1, 8'h1B);
      wr(0, OFF_SHARED3, 8'h01);
      wr(0, OFF_SI_ODD, 8'h80);
      wr(0, OFF_RA_BITS, 8'h01);
      wr(0, OFF_SA4_BITS, 8'h01);
      chan(0, 5'd0, 4'd0, 8'hFF, 8'h9B);
      chan(0, 5'd0, 4'd1, 8'hFF, 8'h70);
      chan(0, 5'd0, 4'd2, 8'hFF, 8'h1B);
      chan(0, 5'd0, 4'd15, 8'hFF, 8'hC0);
      wr(0, OFF_SA5_BITS, 8'h80);
      chan(0, 5'd0, 4'd15, 8'hFF, 8'hC8);
      wr(0, OFF_CTRL, 8'h11);
      chan(0, 5'd0, 4'd0, 8'h3C, 8'h3C);
      $display("slot zero test done");
   endtask

   initial begin
      nrst_in = 1'b0;
      {reg_wr_in, reg_rd_in, ch_valid_in, oh_bit_req_in} = 4'h0;
      reg_addr_in = '0;
      {reg_wdata_in, serial_transmit_input_in} = 16'h0000;
      {ch_port_in, oh_port_in, ch_num_in, oh_index_in} = 14'h0000;
      ch_frame_in = 4'h0;
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      test_regs();
      test_stuff();
      test_link();
      test_e1();
      print_verdict();
   end
endmodule
